/* File: src/tmr8_consts.svh */
// Register offsets, field positions and encodings of the 8-bit timer/counter
`ifndef TMR8_CONSTS_SVH
`define TMR8_CONSTS_SVH

// APB byte addresses
`define TMR8_ADDR_CONTROL 12'h000
`define TMR8_ADDR_COUNTER 12'h004
`define TMR8_ADDR_COMPARE 12'h008
`define TMR8_ADDR_FLAGS 12'h00c
`define TMR8_ADDR_MASK 12'h010
`define TMR8_ADDR_STATUS 12'h014

// Control register fields
`define TMR8_CS_LSB 0
`define TMR8_CS_MSB 2
`define TMR8_WGM_LSB 3
`define TMR8_WGM_MSB 4
`define TMR8_COM_LSB 5
`define TMR8_COM_MSB 6
`define TMR8_FOC_BIT 7

// Flag and mask bit positions
`define TMR8_OVF_BIT 0
`define TMR8_OCF_BIT 1

// Clock select codes
`define TMR8_CS_STOP 3'h0
`define TMR8_CS_DIV1 3'h1
`define TMR8_CS_DIV8 3'h2
`define TMR8_CS_DIV64 3'h3
`define TMR8_CS_DIV256 3'h4
`define TMR8_CS_DIV1024 3'h5
`define TMR8_CS_EXT_FALL 3'h6
`define TMR8_CS_EXT_RISE 3'h7

// Counter extremes and prescaler width
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hff
`define TMR8_PRESC_W 10

`endif

/* File: src/tmr8_pkg.sv */
// Types shared by the 8-bit timer/counter
package tmr8_pkg;
    `include "tmr8_consts.svh"

    // Waveform generation modes
    typedef enum logic [1:0] {
        TMR8_WGM_NORMAL = 2'b00,
        TMR8_WGM_PHASE = 2'b01,
        TMR8_WGM_CTC = 2'b10,
        TMR8_WGM_FAST = 2'b11
    } tmr8_wgm_e;

    // Control fields as one bundle
    typedef struct packed {
        logic [1:0] com;
        tmr8_wgm_e wgm;
        logic [2:0] cs;
    } tmr8_ctrl_s;
endpackage

/* File: src/tmr8_timer.sv */
// 8-bit timer/counter with compare unit behind an APB slave
//
// Functional notes
// [R1] Counter and compare value are 8-bit software read/write registers.
// [R2] Flags sit in a flag register, each gated by its own mask bit.
// [R3] Timer clock comes from prescaler or external count pin with edge select.
// [R4] Clock select zero stops the counter.
// [R5] Counter is readable and writable at any time.
// [R6] Software counter write beats clear, increment and decrement.
// [R7] Bottom indication when counter is zero.
// [R8] Max indication when counter is 255.
// [R9] Top is 255 or compare value depending on mode.
// [R10] Each timer clock clears, increments or decrements by one per mode.
// [R11] Overflow flag set per mode and offered as interrupt request.
// [R12] Equality sets compare match flag at next timer clock.
// [R13] Compare interrupt needs enable bit and global interrupt enable.
// [R14] Match flag cleared by interrupt execution or by writing one.
// [R15] Compare value double buffered in PWM modes only.
// [R16] Buffered compare value moves to active register at top or bottom.
// [R17] Software compare access hits buffer when buffered, else active register.
// [R18] Force strobe updates output as a match, no flag, no counter change.
// [R19] Counter write blocks compare match in next timer clock cycle.
// [R20] Software should avoid writing counter equal to compare or bottom downcounting.
// [R21] Compare output register kept across waveform mode changes.
// [R22] Output mode field is not buffered and acts at once.
// [R23] Mode 0 normal, 2 clear on compare, 3 fast PWM.
// [R24] Clear on compare mode resets counter to zero on match.
// [R25] Output mode zero leaves compare output unchanged on match.
// [R26] Mode 1 counts up to 255 and down to zero.
// [R27] Reset clears counter, compare, control fields and output register.
//
// Design decisions made here: the APB interface to the registers and the address map.
module tmr8_timer
    import tmr8_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_count_pin,
    input wire logic global_irq_enable,
    input wire logic cmp_irq_ack,
    input wire logic ovf_irq_ack,
    output logic compare_output,
    output logic cmp_irq,
    output logic ovf_irq
);

    tmr8_ctrl_s ctrl_q;
    logic [7:0] counter_value_q;
    logic [7:0] compare_value_q;
    logic [7:0] compare_buf_q;
    logic [1:0] flags_q;
    logic [1:0] mask_q;
    logic compare_output_q;
    logic down_q;
    logic block_q;
    logic [`TMR8_PRESC_W-1:0] presc_q;
    logic ext_q;
    logic [31:0] prdata_q;

    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic tick;
    logic pwm_mode;
    logic at_bottom;
    logic at_max;
    logic at_top;
    logic raw_match;
    logic match;
    logic ovf_event;
    logic cnt_wr;
    logic cmp_wr;
    logic force_strobe;
    logic [7:0] cnt_next;
    logic down_next;

    // Bus access decode: single-cycle slave, always ready
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign addr_ok = (paddr == `TMR8_ADDR_CONTROL) || (paddr == `TMR8_ADDR_COUNTER) ||
        (paddr == `TMR8_ADDR_COMPARE) || (paddr == `TMR8_ADDR_FLAGS) ||
        (paddr == `TMR8_ADDR_MASK) || (paddr == `TMR8_ADDR_STATUS);
    assign pslverr = psel && penable && !addr_ok;
    assign cnt_wr = wr_en && (paddr == `TMR8_ADDR_COUNTER);
    assign cmp_wr = wr_en && (paddr == `TMR8_ADDR_COMPARE);
    assign force_strobe = wr_en && (paddr == `TMR8_ADDR_CONTROL) && pwdata[`TMR8_FOC_BIT];

    // Free-running prescaler; it never resets with the clock select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 1'b1;
        end
    end

    // Pin is taken as synchronous; only its previous level is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_q <= 1'b0;
        end else begin
            ext_q <= external_count_pin;
        end
    end

    // [R3] Timer clock selection
    // [R4] Code zero gives no tick at all
    always_comb begin
        case (ctrl_q.cs)
            `TMR8_CS_STOP: tick = 1'b0;
            `TMR8_CS_DIV1: tick = 1'b1;
            `TMR8_CS_DIV8: tick = &presc_q[2:0];
            `TMR8_CS_DIV64: tick = &presc_q[5:0];
            `TMR8_CS_DIV256: tick = &presc_q[7:0];
            `TMR8_CS_DIV1024: tick = &presc_q;
            `TMR8_CS_EXT_FALL: tick = ext_q && !external_count_pin;
            `TMR8_CS_EXT_RISE: tick = !ext_q && external_count_pin;
            default: tick = 1'b0;
        endcase
    end

    // [R7] Bottom and [R8] max indications
    assign at_bottom = (counter_value_q == `TMR8_BOTTOM);
    assign at_max = (counter_value_q == `TMR8_MAX);
    // [R15] PWM modes use the buffered compare value
    assign pwm_mode = (ctrl_q.wgm == TMR8_WGM_PHASE) || (ctrl_q.wgm == TMR8_WGM_FAST);
    // [R9] Top is compare value in clear-on-compare, else 255
    assign at_top = (ctrl_q.wgm == TMR8_WGM_CTC) ? (counter_value_q == compare_value_q) : at_max;
    // [R12] Continuous comparison; [R19] blocked after a counter write
    assign raw_match = (counter_value_q == compare_value_q);
    assign match = tick && raw_match && !block_q;

    // [R10] Next count per mode
    // [R23] Mode decode; [R24] clear on match; [R26] dual slope
    always_comb begin
        cnt_next = counter_value_q;
        down_next = down_q;
        case (ctrl_q.wgm)
            TMR8_WGM_NORMAL: cnt_next = counter_value_q + 8'h01;
            TMR8_WGM_CTC: cnt_next = raw_match ? `TMR8_BOTTOM : counter_value_q + 8'h01;
            TMR8_WGM_FAST: cnt_next = counter_value_q + 8'h01;
            TMR8_WGM_PHASE: begin
                if (down_q && at_bottom) begin
                    down_next = 1'b0;
                    cnt_next = counter_value_q + 8'h01;
                end else if (!down_q && at_max) begin
                    down_next = 1'b1;
                    cnt_next = counter_value_q - 8'h01;
                end else if (down_q) begin
                    cnt_next = counter_value_q - 8'h01;
                end else begin
                    cnt_next = counter_value_q + 8'h01;
                end
            end
            default: cnt_next = counter_value_q;
        endcase
    end

    // [R11] Overflow: wrap to zero, or direction change at bottom in phase mode
    always_comb begin
        case (ctrl_q.wgm)
            TMR8_WGM_PHASE: ovf_event = tick && down_q && at_bottom;
            default: ovf_event = tick && at_max;
        endcase
    end

    // [R6] Software write wins over counting; [R5] any time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value_q <= `TMR8_BOTTOM;
            down_q <= 1'b0;
        end else if (cnt_wr) begin
            counter_value_q <= pwdata[7:0];
        end else if (tick) begin
            counter_value_q <= cnt_next;
            down_q <= down_next;
        end
    end

    // [R19] Block lasts until the next timer clock cycle, even if stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_q <= 1'b0;
        end else if (cnt_wr) begin
            block_q <= 1'b1;
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    // [R17] Compare writes go to buffer or active register
    // [R16] Buffer copied at top (fast) or max turn-around (phase correct)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_value_q <= 8'h00;
            compare_buf_q <= 8'h00;
        end else begin
            if (cmp_wr) begin
                compare_buf_q <= pwdata[7:0];
            end
            if (cmp_wr && !pwm_mode) begin
                compare_value_q <= pwdata[7:0];
            end else if (pwm_mode && tick && at_max) begin
                compare_value_q <= compare_buf_q;
            end
        end
    end

    // [R27] Reset clears fields
    // Control fields; force bit is a strobe and never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= '0;
        end else if (wr_en && (paddr == `TMR8_ADDR_CONTROL)) begin
            ctrl_q.cs <= pwdata[`TMR8_CS_MSB:`TMR8_CS_LSB];
            ctrl_q.wgm <= tmr8_wgm_e'(pwdata[`TMR8_WGM_MSB:`TMR8_WGM_LSB]);
            ctrl_q.com <= pwdata[`TMR8_COM_MSB:`TMR8_COM_LSB];
        end
    end

    // Compare output waveform; [R21] not touched by mode changes
    // [R22] Output mode read live; [R25] zero means no change
    // [R18] Force acts only in non-PWM modes, with the newly written mode field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_output_q <= 1'b0;
        end else if (force_strobe && !pwm_mode) begin
            case (pwdata[`TMR8_COM_MSB:`TMR8_COM_LSB])
                2'h1: compare_output_q <= !compare_output_q;
                2'h2: compare_output_q <= 1'b0;
                2'h3: compare_output_q <= 1'b1;
                default: compare_output_q <= compare_output_q;
            endcase
        end else if (ctrl_q.com != 2'h0) begin
            if (!pwm_mode && match) begin
                case (ctrl_q.com)
                    2'h1: compare_output_q <= !compare_output_q;
                    2'h2: compare_output_q <= 1'b0;
                    default: compare_output_q <= 1'b1;
                endcase
            end else if (ctrl_q.wgm == TMR8_WGM_FAST && ctrl_q.com[1]) begin
                // Inverting when low bit set: set on match, clear at bottom
                if (match) begin
                    compare_output_q <= ctrl_q.com[0];
                end else if (tick && at_max) begin
                    compare_output_q <= !ctrl_q.com[0];
                end
            end else if (ctrl_q.wgm == TMR8_WGM_PHASE && ctrl_q.com[1] && match) begin
                // Clear on up-match, set on down-match (inverted when low bit set)
                compare_output_q <= down_q ^ ctrl_q.com[0];
            end
        end
    end

    // [R12] Flags set on events; set wins over clear
    // [R14] Cleared by acknowledge or by writing one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= 2'h0;
        end else begin
            if (match) begin
                flags_q[`TMR8_OCF_BIT] <= 1'b1;
            end else if (cmp_irq_ack ||
                (wr_en && paddr == `TMR8_ADDR_FLAGS && pwdata[`TMR8_OCF_BIT])) begin
                flags_q[`TMR8_OCF_BIT] <= 1'b0;
            end
            if (ovf_event) begin
                flags_q[`TMR8_OVF_BIT] <= 1'b1;
            end else if (ovf_irq_ack ||
                (wr_en && paddr == `TMR8_ADDR_FLAGS && pwdata[`TMR8_OVF_BIT])) begin
                flags_q[`TMR8_OVF_BIT] <= 1'b0;
            end
        end
    end

    // [R2] Mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= 2'h0;
        end else if (wr_en && (paddr == `TMR8_ADDR_MASK)) begin
            mask_q <= pwdata[1:0];
        end
    end

    // [R13] Requests need flag, mask and global enable
    assign cmp_irq = flags_q[`TMR8_OCF_BIT] && mask_q[`TMR8_OCF_BIT] && global_irq_enable;
    assign ovf_irq = flags_q[`TMR8_OVF_BIT] && mask_q[`TMR8_OVF_BIT] && global_irq_enable;
    assign compare_output = compare_output_q;

    // [R1] Read mux; reads are registered during the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `TMR8_ADDR_CONTROL: prdata_q <= {24'h0, 1'b0, ctrl_q};
                `TMR8_ADDR_COUNTER: prdata_q <= {24'h0, counter_value_q};
                `TMR8_ADDR_COMPARE: prdata_q <= {24'h0, pwm_mode ? compare_buf_q : compare_value_q};
                `TMR8_ADDR_FLAGS: prdata_q <= {30'h0, flags_q};
                `TMR8_ADDR_MASK: prdata_q <= {30'h0, mask_q};
                `TMR8_ADDR_STATUS: prdata_q <= {28'h0, down_q, compare_output_q, at_max, at_bottom};
                default: prdata_q <= 32'h0;
            endcase
        end
    end
    assign prdata = rd_en ? prdata_q : 32'h0;

    // Checks
    a_cnt_write_wins: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        cnt_wr |=> counter_value_q == $past(pwdata[7:0]))
        else $error("counter write lost");
    a_stop_holds: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
        (ctrl_q.cs == `TMR8_CS_STOP && !cnt_wr) |=> $stable(counter_value_q))
        else $error("stopped counter moved");
    a_match_flag: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        match |=> flags_q[`TMR8_OCF_BIT])
        else $error("match flag not set");
    a_block_match: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
        cnt_wr |=> !match)
        else $error("match after counter write");
    a_ctc_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R24]
        (tick && ctrl_q.wgm == TMR8_WGM_CTC && raw_match && !cnt_wr) |=> counter_value_q == 8'h00)
        else $error("ctc did not clear");
    a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        cmp_irq |-> mask_q[`TMR8_OCF_BIT] && global_irq_enable)
        else $error("irq without enable");
    a_ovf_flag: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        ovf_event |=> flags_q[`TMR8_OVF_BIT])
        else $error("overflow flag not set");
    a_ocf_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
        (cmp_irq_ack && !match) |=> !flags_q[`TMR8_OCF_BIT])
        else $error("flag not cleared");
    a_buf_direct: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
        (cmp_wr && !pwm_mode) |=> compare_value_q == $past(pwdata[7:0]))
        else $error("direct compare write lost");
    a_force_noflag: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
        (force_strobe && !match && !flags_q[`TMR8_OCF_BIT]) |=> !flags_q[`TMR8_OCF_BIT])
        else $error("force set flag");
    // PWM periods stay whole because the buffer only moves at the top
    a_buf_load: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
        (pwm_mode && tick && at_max) |=> compare_value_q == $past(compare_buf_q))
        else $error("buffer not loaded at top");
    a_buf_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
        (pwm_mode && cmp_wr && !(tick && at_max)) |=> $stable(compare_value_q))
        else $error("buffered write reached active compare");
    a_out_kept: assert property (@(posedge pclk) disable iff (!presetn) // [R25]
        (ctrl_q.com == 2'h0 && !force_strobe) |=> $stable(compare_output_q))
        else $error("output moved with mode field zero");
    a_force_set: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
        (force_strobe && !pwm_mode && pwdata[`TMR8_COM_MSB:`TMR8_COM_LSB] == 2'h3)
        |=> compare_output_q)
        else $error("force did not set output");
    a_count_step: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        (tick && ctrl_q.wgm == TMR8_WGM_NORMAL && !cnt_wr)
        |=> counter_value_q == $past(counter_value_q) + 8'h01)
        else $error("normal mode did not step by one");
    a_phase_turn: assert property (@(posedge pclk) disable iff (!presetn) // [R26]
        (tick && ctrl_q.wgm == TMR8_WGM_PHASE && !down_q && at_max && !cnt_wr) |=> down_q)
        else $error("phase mode did not turn at max");
    a_ovf_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
        (ovf_irq_ack && !ovf_event) |=> !flags_q[`TMR8_OVF_BIT])
        else $error("overflow flag not cleared");
    // Scenarios the bench is meant to reach
    c_ctc_match: cover property (@(posedge pclk) ctrl_q.wgm == TMR8_WGM_CTC && match);
    c_buf_load: cover property (@(posedge pclk) pwm_mode && tick && at_max);
    c_blocked: cover property (@(posedge pclk) tick && raw_match && block_q);
    c_phase_turn: cover property (@(posedge pclk) ctrl_q.wgm == TMR8_WGM_PHASE && ovf_event);
    c_force: cover property (@(posedge pclk) force_strobe && !pwm_mode);
endmodule

/* File: tb/tmr8_cpu_model.sv */
// Behavioural CPU core that enables and executes the timer interrupts
module tmr8_cpu_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic irq_on,
    input wire logic [3:0] ack_delay,
    input wire logic cmp_irq,
    input wire logic ovf_irq,
    output logic global_irq_enable,
    output logic cmp_irq_ack,
    output logic ovf_irq_ack
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] wait_q;

    assign global_irq_enable = irq_on;

    // vector execution acks
    // A slow core waits ack_delay cycles; compare vector is served first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 4'h0;
            cmp_irq_ack <= 1'b0;
            ovf_irq_ack <= 1'b0;
        end else begin
            cmp_irq_ack <= 1'b0;
            ovf_irq_ack <= 1'b0;
            if ((cmp_irq || ovf_irq) && !cmp_irq_ack && !ovf_irq_ack) begin
                if (wait_q == ack_delay) begin
                    wait_q <= 4'h0;
                    cmp_irq_ack <= cmp_irq;
                    ovf_irq_ack <= !cmp_irq;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end else begin
                wait_q <= 4'h0;
            end
        end
    end
endmodule

/* File: tb/tb_tmr8_timer.sv */
// Self-checking bench for the timer/counter through its APB registers
`include "tmr8_consts.svh"
module tb_tmr8_timer;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, err, ext_pin = 1'b0, irq_on = 1'b0, glob_ie;
    logic cmp_ack, ovf_ack, cmp_out, cmp_irq, ovf_irq;
    logic [3:0] ack_delay = 4'h0;
    int n_mismatch = 0, n_compared = 0;
    logic [1:0] com_tab [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic out_tab [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

    tmr8_timer i_tmr8_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_pin(ext_pin), .global_irq_enable(glob_ie),
        .cmp_irq_ack(cmp_ack), .ovf_irq_ack(ovf_ack), .compare_output(cmp_out),
        .cmp_irq(cmp_irq), .ovf_irq(ovf_irq));

    tmr8_cpu_model i_tmr8_cpu_model (.pclk(pclk), .presetn(presetn), .irq_on(irq_on),
        .ack_delay(ack_delay), .cmp_irq(cmp_irq), .ovf_irq(ovf_irq),
        .global_irq_enable(glob_ie), .cmp_irq_ack(cmp_ack), .ovf_irq_ack(ovf_ack));

    // 25 MHz clock
    always #20 pclk = ~pclk;

    // One APB transfer; holds the request until pready is seen high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a);
        xfer(1'b0, a, 32'h0);
    endtask

    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Running counts land in a window because start and stop cost bus cycles
    task automatic check_range(input string name, input int lo, input int hi,
                               input logic [31:0] got);
        n_compared++;
        if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            n_mismatch++;
            $display("wrong value %s expected %0d..%0d seen %h", name, lo, hi, got);
        end
    endtask

    // Pins are looked at mid-cycle, well after the edge that launches them
    task automatic check_pin(input string name, input logic exp, input int sel);
        logic got;
        @(negedge pclk);
        got = (sel == 0) ? cmp_out : ((sel == 1) ? cmp_irq : ovf_irq);
        check_val(name, {31'h0, exp}, {31'h0, got});
        @(posedge pclk);
    endtask

    // Start with a control byte, let it run, then stop keeping mode fields
    task automatic run_ticks(input logic [7:0] ctl, input int n);
        wr(`TMR8_ADDR_CONTROL, {24'h0, ctl});
        repeat (n) @(posedge pclk);
        wr(`TMR8_ADDR_CONTROL, {24'h0, ctl & 8'hf8});
    endtask

    task complete_run;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog well beyond the roughly 5100 cycles the sequence needs
    initial begin
        repeat (40000) @(posedge pclk);
        n_mismatch++;
        complete_run;
    end

    // Main sequence
    initial begin
        int sh;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(12'(i * 4));
            check_val("reset value", (i == 5) ? 32'h1 : 32'h0, rdv);
        end
        rd(12'h018);
        check_val("unmapped data", 32'h0, rdv);
        check_val("unmapped error", 32'h1, {31'h0, err});
        wr(`TMR8_ADDR_COUNTER, 32'hffff_ffa5);
        rd(`TMR8_ADDR_COUNTER);
        check_val("counter", 32'ha5, rdv);
        wr(`TMR8_ADDR_COMPARE, 32'h5a);
        rd(`TMR8_ADDR_COMPARE);
        check_val("compare", 32'h5a, rdv);
        wr(`TMR8_ADDR_COUNTER, 32'hff);
        repeat (20) @(posedge pclk);
        rd(`TMR8_ADDR_STATUS);
        check_val("status at max", 32'h2, rdv);
        rd(`TMR8_ADDR_COUNTER);
        check_val("stopped counter", 32'hff, rdv);
        for (int c = 6; c <= 7; c++) begin
            wr(`TMR8_ADDR_COUNTER, 32'h0);
            wr(`TMR8_ADDR_CONTROL, 32'(c));
            repeat (3) begin
                repeat (4) @(posedge pclk);
                ext_pin <= 1'b1;
                repeat (4) @(posedge pclk);
                ext_pin <= 1'b0;
            end
            repeat (6) @(posedge pclk);
            wr(`TMR8_ADDR_CONTROL, 32'h0);
            rd(`TMR8_ADDR_COUNTER);
            check_val("pin count", 32'h3, rdv);
        end
        for (int c = 2; c <= 5; c++) begin
            sh = (c == 2) ? 3 : 2 * c;
            wr(`TMR8_ADDR_COUNTER, 32'h0);
            run_ticks(8'(c), 1024);
            rd(`TMR8_ADDR_COUNTER);
            check_range("prescaled count", (1024 >> sh) - 1, (1024 >> sh) + 2, rdv);
        end
        // wrap sets overflow
        // Prescaled runs passed the compare value, so drop that match first
        wr(`TMR8_ADDR_FLAGS, 32'h3);
        wr(`TMR8_ADDR_COMPARE, 32'h80);
        wr(`TMR8_ADDR_COUNTER, 32'hfe);
        run_ticks(8'h01, 6);
        rd(`TMR8_ADDR_FLAGS);
        check_val("overflow flag", 32'h1, rdv);
        rd(`TMR8_ADDR_COUNTER);
        check_range("wrapped counter", 2, 8, rdv);
        wr(`TMR8_ADDR_MASK, 32'h1);
        irq_on <= 1'b1;
        check_pin("overflow irq", 1'b1, 2);
        repeat (4) @(posedge pclk);
        rd(`TMR8_ADDR_FLAGS);
        check_val("flags after vector", 32'h0, rdv);
        irq_on <= 1'b0;
        // equal value only while output unused
        wr(`TMR8_ADDR_COMPARE, 32'h10);
        wr(`TMR8_ADDR_COUNTER, 32'h10);
        run_ticks(8'h01, 4);
        rd(`TMR8_ADDR_FLAGS);
        check_val("blocked match", 32'h0, rdv);
        wr(`TMR8_ADDR_COUNTER, 32'h0e);
        run_ticks(8'h01, 6);
        rd(`TMR8_ADDR_FLAGS);
        check_val("match flag", 32'h2, rdv);
        ack_delay <= 4'h8;
        wr(`TMR8_ADDR_MASK, 32'h0);
        irq_on <= 1'b1;
        repeat (2) @(posedge pclk);
        check_pin("masked irq", 1'b0, 1);
        irq_on <= 1'b0;
        wr(`TMR8_ADDR_MASK, 32'h2);
        check_pin("global off irq", 1'b0, 1);
        irq_on <= 1'b1;
        repeat (2) @(posedge pclk);
        check_pin("compare irq", 1'b1, 1);
        repeat (12) @(posedge pclk);
        rd(`TMR8_ADDR_FLAGS);
        check_val("flag after slow vector", 32'h0, rdv);
        irq_on <= 1'b0;
        wr(`TMR8_ADDR_MASK, 32'h0);
        wr(`TMR8_ADDR_COMPARE, 32'h05);
        wr(`TMR8_ADDR_COUNTER, 32'h0);
        run_ticks(8'h11, 40);
        rd(`TMR8_ADDR_COUNTER);
        check_range("cleared counter", 0, 5, rdv);
        rd(`TMR8_ADDR_FLAGS);
        check_val("clear mode flags", 32'h2, rdv);
        wr(`TMR8_ADDR_FLAGS, 32'h3);
        wr(`TMR8_ADDR_COUNTER, 32'h33);
        foreach (com_tab[i]) begin
            wr(`TMR8_ADDR_CONTROL, {24'h0, 1'b1, com_tab[i], 5'h0});
            check_pin("forced output", out_tab[i], 0);
        end
        rd(`TMR8_ADDR_FLAGS);
        check_val("flags after force", 32'h0, rdv);
        rd(`TMR8_ADDR_COUNTER);
        check_val("counter after force", 32'h33, rdv);
        wr(`TMR8_ADDR_COMPARE, 32'h20);
        wr(`TMR8_ADDR_CONTROL, 32'h18);
        check_pin("output after mode change", 1'b1, 0);
        wr(`TMR8_ADDR_COMPARE, 32'h05);
        rd(`TMR8_ADDR_COMPARE);
        check_val("compare buffer", 32'h05, rdv);
        wr(`TMR8_ADDR_COUNTER, 32'h02);
        run_ticks(8'h19, 6);
        rd(`TMR8_ADDR_FLAGS);
        check_val("no early match", 32'h0, rdv);
        run_ticks(8'h19, 300);
        rd(`TMR8_ADDR_FLAGS);
        check_val("fast pwm flags", 32'h3, rdv);
        wr(`TMR8_ADDR_FLAGS, 32'h3);
        wr(`TMR8_ADDR_COUNTER, 32'h0);
        run_ticks(8'h09, 300);
        rd(`TMR8_ADDR_COUNTER);
        check_range("down count", 200, 225, rdv);
        rd(`TMR8_ADDR_STATUS);
        check_val("direction", 32'h1, {31'h0, rdv[3]});
        rd(`TMR8_ADDR_FLAGS);
        check_val("no turn overflow", 32'h0, {31'h0, rdv[0]});
        complete_run;
    end
endmodule
